// ==== core/ncq_cmd_pkg.sv ====
package ncq_cmd_pkg;
  // Command opcode of the queued non-data command
  localparam logic [7:0] OPC_NCQ_NONDATA = 8'h63;
  // Subcommand codes, low nibble of the current feature byte
  localparam logic [3:0] SUB_DEADLINE = 4'h1;
  localparam logic [3:0] SUB_SET_FEATURES = 4'h5;
  // Feature byte field positions
  localparam int FEAT_WR_STRICT_BIT = 4;
  localparam int FEAT_RD_STRICT_BIT = 5;
  // Tag lies in bits 7:3 of its byte
  localparam int TAG_LSB = 3;
  // Priority code for isochronous deadline-dependent commands
  localparam logic [1:0] ISOCH_PRIORITY = 2'b01;
  // Status byte bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SEEK_COMPLETE = 4;
  localparam int ST_ERR = 0;
  // Error byte bit positions
  localparam int ER_ABORTED = 2;
  // Reset values of the status and error bytes
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  // Status byte of a good completion: ready, seek complete
  localparam logic [7:0] STATUS_GOOD = 8'h50;
  // Status byte of an abort: ready, seek complete, error
  localparam logic [7:0] STATUS_FAIL = 8'h51;
  // Error byte of an abort: command aborted only
  localparam logic [7:0] ERROR_ABORT = 8'h04;

  // Command block fields as delivered in the host-to-device FIS
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] feature_cur;
    logic [7:0] feature_prev;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] sector_num_cur;
    logic [7:0] cyl_low_cur;
    logic [7:0] cyl_high_cur;
  } cmd_fields_t;

  // Fields of an outgoing status FIS
  typedef struct packed {
    logic intr;
    logic [7:0] status;
    logic [7:0] error;
    logic [31:0] act;
  } fis_out_t;

  // Forwarded set-features request
  typedef struct packed {
    logic [7:0] subfeature;
    logic [27:0] param;
  } setfeat_t;
endpackage : ncq_cmd_pkg

// ==== core/ncq_nondata_subcommand_decoder.sv ====
// Summary of operation
// - Feature low nibble 1h selects deadline handling
// - Feature low nibble 5h selects queued set-features
// - Supported deadline handling completes without error
// - Deadline success answered by Set Device Bits
// - Abort deadline handling while queuing disabled
// - Abort on target tag equal or invalid
// - Abort on unsupported abort-type parameter
// - Write strict clear: late writes allowed
// - Write strict set: late write aborts all timed commands
// - Write strictness only for isochronous priority writes
// - Read strict clear: late reads allowed
// - Read strict set: late read aborts all timed commands
// - Read strictness only for isochronous priority reads
// - Set-features success: SDB, interrupt, completed tags
// - Set-features success: error bit and byte zero
// - Early error: register FIS, error set, busy clear
// - Set-features takes previous feature and count bytes
// - Parameter upper bytes from number and cylinders
module ncq_nondata_subcommand_decoder #(
  parameter int NUM_TAGS = 32,
  parameter int TIMER_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire ncq_cmd_pkg::cmd_fields_t cmd_fields,
  input wire logic ncq_enabled,
  input wire logic [4:0] max_queue_tag,
  input wire logic [TIMER_W-1:0] completion_time_limit,
  input wire logic queue_issue,
  input wire logic [4:0] queue_issue_tag,
  input wire logic queue_issue_write,
  input wire logic [1:0] queue_priority,
  input wire logic [NUM_TAGS-1:0] queue_done,
  output logic sdb_valid,
  output logic d2h_valid,
  output ncq_cmd_pkg::fis_out_t fis_out,
  output logic setfeat_valid,
  output ncq_cmd_pkg::setfeat_t setfeat_out,
  output logic abort_outstanding,
  output logic [NUM_TAGS-1:0] abort_mask,
  output logic write_deadline_strict,
  output logic read_deadline_strict,
  output logic [7:0] command_status_flags,
  output logic [7:0] command_error_flags
);
  import ncq_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic is_ours; // Opcode matches the queued non-data command
  logic sub_deadline; // Deadline handling requested
  logic sub_setfeat; // Queued set-features requested
  logic [4:0] own_tag; // Tag of this request
  logic [4:0] target_tag; // Tag the deadline request points at
  logic deadline_bad; // Any abort reason for deadline handling
  logic accept_ok; // Request completes good
  logic expire_any; // A strict deadline ran out this cycle
  logic [NUM_TAGS-1:0] expired; // Per-tag strict expiry
  logic [NUM_TAGS-1:0] completed; // Tags done since last notification
  logic [NUM_TAGS-1:0] tag_live; // Tags with a running timer

  assign is_ours = cmd_valid && (cmd_fields.command == OPC_NCQ_NONDATA);
  // Subcommand picked from the low nibble only
  assign sub_deadline = cmd_fields.feature_cur[3:0] == SUB_DEADLINE;
  assign sub_setfeat = cmd_fields.feature_cur[3:0] == SUB_SET_FEATURES;
  // Host places both tags in bits 7:3 of their bytes
  assign own_tag = cmd_fields.count_cur[7:TAG_LSB];
  assign target_tag = cmd_fields.sector_num_cur[7:TAG_LSB];

  // Abort reasons; bits 7:6 carry no supported abort type here
  always_comb
  begin
    deadline_bad = 1'b0;
    if (!ncq_enabled)
    begin
      deadline_bad = 1'b1;
    end
    if ((target_tag == own_tag) || (target_tag > max_queue_tag))
    begin
      deadline_bad = 1'b1;
    end
    if (cmd_fields.feature_cur[7:6] != 2'b00)
    begin
      deadline_bad = 1'b1;
    end
  end

  // Good completion: supported subcommand and no abort reason
  assign accept_ok = (sub_deadline && !deadline_bad) || sub_setfeat;

  ////////////////////////////////////////////////////////////////////////////
  // Status FIS generation

  // One response per command with our opcode, good or aborted, one cycle after it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sdb_valid <= 1'b0;
      d2h_valid <= 1'b0;
      fis_out <= '0;
    end
    else
    begin
      sdb_valid <= 1'b0;
      d2h_valid <= 1'b0;
      if (is_ours && accept_ok)
      begin
        // Good end: SDB with own tag plus any other finished tags
        sdb_valid <= 1'b1;
        fis_out.intr <= 1'b1;
        fis_out.status <= STATUS_GOOD;
        fis_out.error <= 8'h00;
        fis_out.act <= completed | (NUM_TAGS'(1) << own_tag);
      end
      else if (is_ours)
      begin
        // Not yet acknowledged, so errors go out as a register FIS
        d2h_valid <= 1'b1;
        fis_out.intr <= 1'b1;
        fis_out.status <= STATUS_FAIL;
        fis_out.error <= ERROR_ABORT;
        fis_out.act <= '0;
      end
    end
  end

  // Completed tags gathered until the next SDB; a new one wins the clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      completed <= '0;
    end
    else if (is_ours && accept_ok)
    begin
      completed <= queue_done;
    end
    else
    begin
      completed <= completed | queue_done;
    end
  end

  // Visible status and error bytes follow the last response
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      command_status_flags <= STATUS_RESET;
      command_error_flags <= ERROR_RESET;
    end
    else if (is_ours)
    begin
      command_status_flags <= accept_ok ? STATUS_GOOD : STATUS_FAIL;
      command_error_flags <= accept_ok ? 8'h00 : ERROR_ABORT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deadline mode and set-features forwarding

  // Strictness latched only by a good deadline request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      write_deadline_strict <= 1'b0;
      read_deadline_strict <= 1'b0;
    end
    else if (is_ours && sub_deadline && !deadline_bad)
    begin
      write_deadline_strict <= cmd_fields.feature_cur[FEAT_WR_STRICT_BIT];
      read_deadline_strict <= cmd_fields.feature_cur[FEAT_RD_STRICT_BIT];
    end
  end

  // Set-features bytes forwarded to the feature engine
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      setfeat_valid <= 1'b0;
      setfeat_out <= '0;
    end
    else
    begin
      setfeat_valid <= is_ours && sub_setfeat;
      if (is_ours && sub_setfeat)
      begin
        setfeat_out.subfeature <= cmd_fields.feature_prev;
        setfeat_out.param[7:0] <= cmd_fields.count_prev;
        setfeat_out.param[27:24] <= cmd_fields.sector_num_cur[3:0];
        setfeat_out.param[23:16] <= cmd_fields.cyl_high_cur;
        setfeat_out.param[15:8] <= cmd_fields.cyl_low_cur;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-tag deadline timers

  // One down-counter per tag; only isochronous commands are timed
  for (genvar t = 0; t < NUM_TAGS; t++)
  begin : g_timer
    logic [TIMER_W-1:0] remain; // Cycles left before the deadline
    logic live; // Timer running
    logic is_write; // Timed command is a write
    logic load; // Issue of this tag

    assign load = queue_issue && (queue_issue_tag == 5'(t))
      && (queue_priority == ISOCH_PRIORITY);
    assign tag_live[t] = live;
    // Expiry counts only where the matching strict bit is set
    assign expired[t] = live && (remain == '0) && !queue_done[t]
      && (is_write ? write_deadline_strict : read_deadline_strict);

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        live <= 1'b0;
        remain <= '0;
        is_write <= 1'b0;
      end
      else if (load)
      begin
        live <= 1'b1;
        remain <= completion_time_limit;
        is_write <= queue_issue_write;
      end
      else if (queue_done[t] || expire_any)
      begin
        // Finished, or swept away by a strict abort
        live <= 1'b0;
      end
      else if (live && (remain != '0))
      begin
        // Non-strict timers simply park at zero
        remain <= remain - 1'b1;
      end
    end
  end

  assign expire_any = |expired;

  // A missed strict deadline aborts every outstanding timed command
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      abort_outstanding <= 1'b0;
      abort_mask <= '0;
    end
    else
    begin
      abort_outstanding <= expire_any;
      abort_mask <= expire_any ? tag_live : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_DEADLINE_GOOD: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_deadline && ncq_enabled && (target_tag != own_tag)
    && (target_tag <= max_queue_tag) && (cmd_fields.feature_cur[7:6] == 2'b00)
    |=> sdb_valid && !d2h_valid)
    else $error("good deadline request not answered by SDB");

  AST_NCQ_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_deadline && !ncq_enabled |=> d2h_valid && !sdb_valid)
    else $error("deadline request with queuing off not aborted");

  AST_TARGET_SELF: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_deadline && (target_tag == own_tag)
    |=> d2h_valid && fis_out.error[ER_ABORTED])
    else $error("target tag equal to own tag not aborted");

  // Abort type field other than 00 must be refused with a register FIS and no SDB
  AST_ABORT_TYPE: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_deadline && (cmd_fields.feature_cur[7:6] != 2'b00)
    |=> d2h_valid && !sdb_valid)
    else $error("unsupported abort type not aborted");

  AST_UNKNOWN_SUB: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && !sub_deadline && !sub_setfeat
    |=> d2h_valid && !setfeat_valid && $stable(write_deadline_strict))
    else $error("unknown subcommand not aborted cleanly");

  AST_SDB_CLEAN: assert property (@(posedge ref_clk) disable iff (rst)
    sdb_valid |-> fis_out.intr && !fis_out.status[ST_ERR]
    && (fis_out.error == 8'h00) && fis_out.act[$past(own_tag)])
    else $error("SDB carries error or lacks own tag");

  // Good status shows ready and seek complete with busy clear
  AST_GOOD_READY: assert property (@(posedge ref_clk) disable iff (rst)
    sdb_valid |-> fis_out.status[ST_RDY] && fis_out.status[ST_SEEK_COMPLETE]
    && !fis_out.status[ST_BSY])
    else $error("SDB status lacks ready bits");

  // Every tag gathered before the command rides in its SDB
  AST_SDB_ACT: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && accept_ok |=> sdb_valid
    && ((fis_out.act & $past(completed)) == $past(completed)))
    else $error("SDB misses a completed tag");

  AST_D2H_FORM: assert property (@(posedge ref_clk) disable iff (rst)
    d2h_valid |-> fis_out.status[ST_ERR] && !fis_out.status[ST_BSY]
    && (command_error_flags == ERROR_ABORT))
    else $error("register FIS has wrong error or busy");

  AST_SETFEAT_MAP: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_setfeat |=> setfeat_valid && sdb_valid
    && (setfeat_out.param == {$past(cmd_fields.sector_num_cur[3:0]),
    $past(cmd_fields.cyl_high_cur), $past(cmd_fields.cyl_low_cur),
    $past(cmd_fields.count_prev)}))
    else $error("set-features parameters wrongly assembled");

  // Subfeature byte comes from the previous feature field
  AST_SETFEAT_SUB: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && sub_setfeat
    |=> setfeat_out.subfeature == $past(cmd_fields.feature_prev))
    else $error("set-features subfeature wrongly taken");

  // Commands of other priorities never start a deadline timer
  AST_UNTIMED: assert property (@(posedge ref_clk) disable iff (rst)
    queue_issue && (queue_priority != ISOCH_PRIORITY) && !tag_live[queue_issue_tag]
    |=> !tag_live[$past(queue_issue_tag)])
    else $error("non-isochronous command was timed");

  AST_STRICT_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
    is_ours && accept_ok && sub_deadline
    |=> write_deadline_strict == $past(cmd_fields.feature_cur[FEAT_WR_STRICT_BIT]))
    else $error("write strict bit not taken");

  AST_EXPIRE_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
    expire_any
    |=> abort_outstanding && ((abort_mask & $past(expired)) == $past(expired)))
    else $error("strict expiry did not abort outstanding commands");

  AST_LAX_NO_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
    !write_deadline_strict && !read_deadline_strict |=> !abort_outstanding)
    else $error("abort raised with no strict mode");

endmodule // ncq_nondata_subcommand_decoder

// ==== tb/host_model.sv ====
// Host side: issues queued commands and completions
module host_model
(
  input wire logic ref_clk,
  output logic cmd_valid,
  output ncq_cmd_pkg::cmd_fields_t cmd_fields,
  output logic ncq_enabled,
  output logic [4:0] max_queue_tag,
  output logic [31:0] completion_time_limit,
  output logic queue_issue,
  output logic [4:0] queue_issue_tag,
  output logic queue_issue_write,
  output logic [1:0] queue_priority,
  output logic [31:0] queue_done
);
  timeunit 1ns;
  timeprecision 100ps;
  import ncq_cmd_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Idle values; short deadline keeps the run brief
  initial
  begin
    cmd_valid = 1'b0;
    cmd_fields = '0;
    ncq_enabled = 1'b1;
    max_queue_tag = 5'h0f;
    completion_time_limit = 32'h3;
    queue_issue = 1'b0;
    queue_issue_tag = 5'h00;
    queue_issue_write = 1'b0;
    queue_priority = 2'b00;
    queue_done = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One FIS, held for one taking edge; released fields are inverted
  task automatic send(input cmd_fields_t c, input logic en);
    @(posedge ref_clk);
    #1;
    cmd_fields = c;
    ncq_enabled = en;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_fields = ~c;
  endtask
  // Queued read or write issue, one cycle
  task automatic issue(input logic [4:0] t, input logic w, input logic [1:0] p);
    @(posedge ref_clk);
    #1;
    queue_issue = 1'b1;
    queue_issue_tag = t;
    queue_issue_write = w;
    queue_priority = p;
    @(posedge ref_clk);
    #1;
    queue_issue = 1'b0;
    queue_issue_tag = ~t;
    queue_issue_write = ~w;
    queue_priority = ~p;
  endtask
  // Completion of tags, one cycle
  task automatic finish(input logic [31:0] m);
    @(posedge ref_clk);
    #1;
    queue_done = m;
    @(posedge ref_clk);
    #1;
    queue_done = '0;
  endtask
endmodule // host_model

// ==== tb/ncq_nondata_subcommand_decoder_tb.sv ====
module ncq_nondata_subcommand_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ncq_cmd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, ncq_enabled, queue_issue, queue_issue_write;
  cmd_fields_t cmd_fields;
  logic [4:0] max_queue_tag, queue_issue_tag;
  logic [31:0] completion_time_limit, queue_done, abort_mask;
  logic [1:0] queue_priority;
  logic sdb_valid, d2h_valid, setfeat_valid, abort_outstanding;
  logic write_deadline_strict, read_deadline_strict;
  fis_out_t fis_out;
  setfeat_t setfeat_out;
  logic [7:0] command_status_flags, command_error_flags;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic seen;
  logic [31:0] m;
  ////////////////////////////////////////////////////////////////////////
  host_model host_model_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_fields(cmd_fields), .ncq_enabled(ncq_enabled), .max_queue_tag(max_queue_tag),
    .completion_time_limit(completion_time_limit), .queue_issue(queue_issue),
    .queue_issue_tag(queue_issue_tag), .queue_issue_write(queue_issue_write),
    .queue_priority(queue_priority), .queue_done(queue_done));
  ncq_nondata_subcommand_decoder ncq_nondata_subcommand_decoder_i (.ref_clk(ref_clk),
    .rst(rst), .cmd_valid(cmd_valid), .cmd_fields(cmd_fields), .ncq_enabled(ncq_enabled),
    .max_queue_tag(max_queue_tag), .completion_time_limit(completion_time_limit),
    .queue_issue(queue_issue), .queue_issue_tag(queue_issue_tag),
    .queue_issue_write(queue_issue_write), .queue_priority(queue_priority),
    .queue_done(queue_done), .sdb_valid(sdb_valid), .d2h_valid(d2h_valid),
    .fis_out(fis_out), .setfeat_valid(setfeat_valid), .setfeat_out(setfeat_out),
    .abort_outstanding(abort_outstanding), .abort_mask(abort_mask),
    .write_deadline_strict(write_deadline_strict),
    .read_deadline_strict(read_deadline_strict),
    .command_status_flags(command_status_flags),
    .command_error_flags(command_error_flags));
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Deadline-style command: tag and target tag in bits 7:3
  function automatic cmd_fields_t mk(input logic [7:0] f, input logic [4:0] t, tt);
    mk = {OPC_NCQ_NONDATA, f, 8'h00, t, 3'h0, 8'h00, tt, 3'h0, 16'h0000};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Response kind, bytes and completion bits in one go
  task automatic chk_fis(input logic sdb, input logic [7:0] st, er, input logic [31:0] act);
    chk(32'({sdb_valid, d2h_valid, fis_out.intr}), 32'({sdb, ~sdb, 1'b1}));
    chk(32'({fis_out.status, fis_out.error}), 32'({st, er}));
    chk(32'({command_status_flags, command_error_flags}), 32'({st, er}));
    chk(fis_out.act, act);
  endtask
  // Watch a bounded window for a strict-deadline abort
  task automatic watch(output logic s, output logic [31:0] mm);
    s = 1'b0;
    mm = '0;
    repeat (10)
    begin
      @(posedge ref_clk);
      #1;
      if (abort_outstanding === 1'b1)
      begin
        s = 1'b1;
        mm = abort_mask;
      end
    end
  endtask
  task automatic results;
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    static logic [7:0] af [6] = '{8'h31, 8'h01, 8'h01, 8'h41, 8'h00, 8'h02};
    static logic [4:0] at [6] = '{5'd2, 5'd6, 5'd2, 5'd2, 5'd2, 5'd2};
    static logic [4:0] att [6] = '{5'd5, 5'd6, 5'd16, 5'd5, 5'd5, 5'd5};
    static logic [1:0] tp [6] = '{2'b01, 2'b10, 2'b01, 2'b00, 2'b01, 2'b01};
    static logic [5:0] tw = 6'b010011;
    static logic [5:0] ts = 6'b000101;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk(32'({command_status_flags, command_error_flags}), 32'h5000);
    chk(32'({write_deadline_strict, read_deadline_strict}), 32'h0);
    // Good deadline request sets both strict bits
    host_model_i.send(mk(8'h31, 5'd2, 5'd5), 1'b1);
    chk_fis(1'b1, STATUS_GOOD, 8'h00, 32'h4);
    chk(32'({write_deadline_strict, read_deadline_strict}), 32'h3);
    // Abort cases: queuing off, tag clash, bad tag, abort type, subcommand
    for (int i = 0; i < 6; i++)
    begin
      host_model_i.send(mk(af[i], at[i], att[i]), i != 0);
      chk_fis(1'b0, STATUS_FAIL, ERROR_ABORT, 32'h0);
    end
    chk(32'({write_deadline_strict, read_deadline_strict}), 32'h3);
    // Queued set-features after a completion of tag 3
    host_model_i.finish(32'h8);
    host_model_i.send({8'h63, 8'h05, 8'ha5, 8'h20, 8'hb6, 8'hc7, 8'hd8, 8'he9}, 1'b1);
    chk_fis(1'b1, STATUS_GOOD, 8'h00, 32'h18);
    chk(32'(setfeat_valid), 32'h1);
    chk(32'(setfeat_out.subfeature), 32'ha5);
    chk(32'(setfeat_out.param), 32'h7e9d8b6);
    // Timed commands: strict then relaxed, both directions, priorities 00, 01 and 10
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4)
      begin
        host_model_i.send(mk(8'h01, 5'd9, 5'd1), 1'b1);
        chk(32'({write_deadline_strict, read_deadline_strict}), 32'h0);
      end
      host_model_i.issue(5'(i), tw[i], tp[i]);
      watch(seen, m);
      chk(32'(seen), 32'(ts[i]));
      chk(m, ts[i] ? (32'h1 << i) : 32'h0);
    end
    results();
  end
endmodule // ncq_nondata_subcommand_decoder_tb
